// ---- src/palette_key_diag_regs.v ----
// Summary of operation
// - key value is ANDed with key mask before any key comparison
// - key control bit 0 enables key matching in key modes; resets zero
// - key enable ignored for packed 24, straight 16 RGB, VGA input
// - double-buffer variant: bit 0 is key enable in 16 YUV and 32
// - double-buffer variant 16 RGB: bit 0 suppresses buffer B
// - suppress 0 gives normal double buffering, 1 shows buffer A only
// - four read/write 8-bit colour converter constants at consecutive indices
// - read-only revision level register
// - read-only product identification code register
// - sense bits 2:0 are raw comparator outputs, unlatched
// - bits 6:4 latch raw bits during active line time only
// - bit 3 is AND of raw comparator bits
// - bit 7 is AND of latched comparator bits
// - active-low sense pin follows raw or latched combined bit per select
// - signature done bit: 0 idle or incomplete, 1 finished; resets zero
// - three signature registers compress red, green, blue converter inputs
// - signature control and blanking (border in interlace) govern signature
// - standard PLL mode returns P, C, M, N at widths 3,2,7,6
// - compatibility mode: 8e gives freq field and vco count, 8f ref count
// - divider readback source picked by source, fs inputs, internal fs
// - low mask bit n zeroes pixel inputs 4n+3..4n when enabled
// - high mask zeroes pixel inputs 63..32 likewise when enabled
//
// Implementation choice: register access over APB.
`include "palette_key_diag_map.vh"
`timescale 1ns/1ns
`default_nettype none
module palette_key_diag_regs (
    input  wire        mclk_i,
    input  wire        rst_b_i,
    input  wire        psel_i,
    input  wire        penable_i,
    input  wire        pwrite_i,
    input  wire [13:0] paddr_i,
    input  wire [31:0] pwdata_i,
    output reg         pready_o,
    output reg  [31:0] prdata_o,
    output reg         pslverr_o,
    input  wire [2:0]  pixel_mode_i,
    input  wire [2:0]  raw_compare_i,
    input  wire        blank_b_i,
    input  wire        border_b_i,
    input  wire [7:0]  dac_red_i,
    input  wire [7:0]  dac_green_i,
    input  wire [7:0]  dac_blue_i,
    input  wire [1:0]  frequency_select_inputs_i,
    input  wire [7:0]  pll_p_sel_i,
    input  wire [7:0]  pll_c_sel_i,
    input  wire [7:0]  pll_m_sel_i,
    input  wire [7:0]  pll_n_sel_i,
    input  wire [7:0]  vco_divider_sel_i,
    input  wire [7:0]  ref_divider_sel_i,
    input  wire [63:0] pixel_port_i,
    output reg  [63:0] pixel_port_o,
    output reg  [7:0]  masked_key_o,
    output reg         key_active_o,
    output reg         second_buffer_suppress_o,
    output reg  [31:0] colour_constants_o,
    output reg         sense_b_o,
    output reg  [2:0]  pll_source_select_o,
    output reg  [3:0]  internal_frequency_select_o
);
////////////////////////////////////////////////////////////////////////////////
localparam [2:0] ST_IDLE = 3'b001;
localparam [2:0] ST_RUN  = 3'b010;
localparam [2:0] ST_DONE = 3'b100;

reg  [7:0] key_value_reg;
reg  [7:0] key_mask_reg;
reg        key_ctrl_reg;
reg  [7:0] const_reg [0:3];
reg  [5:0] misc_reg;
reg  [6:0] pll_ctrl_reg;
reg  [7:0] mask_low_reg;
reg  [7:0] mask_high_reg;
reg  [2:0] latched_reg;
reg  [7:0] sig_red_reg;
reg  [7:0] sig_green_reg;
reg  [7:0] sig_blue_reg;
reg  [2:0] sig_state_reg;
reg  [7:0] pll_m_reg;
reg  [7:0] pll_n_reg;
reg        boot_reg;
reg  [7:0] rd_byte;

wire [11:0] idx      = paddr_i[13:2];
wire        wr_en    = psel_i & penable_i & pwrite_i;
wire        raw_sense = &raw_compare_i;
wire        lat_sense = &latched_reg;
wire        active_line = blank_b_i & (border_b_i | ~misc_reg[`MISC_BORDER_USED]);
wire        sig_window = blank_b_i & (border_b_i | ~misc_reg[`MISC_INTERLACE]);
wire        std_pll  = (pll_ctrl_reg[2:0] == `SRC_STD_A) | (pll_ctrl_reg[2:0] == `SRC_STD_B);
wire        mode_keyed = (pixel_mode_i == `MODE_YUV16) | (pixel_mode_i == `MODE_BPP32);
wire        mode_db  = (pixel_mode_i == `MODE_RGB16) & misc_reg[`MISC_VARIANT_DB];

// one signature step: shift with feedback, then fold in the parallel word
function [7:0] sig_step;
    input [7:0] cur;
    input [7:0] din;
    begin
        sig_step = ({cur[6:0], 1'b0} ^ (cur[7] ? `SIG_POLY : 8'h00)) ^ din;
    end
endfunction

// the converter constants span four consecutive indices
function in_const_bank;
    input [11:0] at;
    begin
        in_const_bank = (at >= `IDX_CONST_ONE) && (at <= `IDX_CONST_FOUR);
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// register writes; read-only indices fall through untouched
always @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
        key_value_reg <= 8'h00;
        key_mask_reg  <= 8'h00;
        key_ctrl_reg  <= 1'b0;
        const_reg[0]  <= 8'h00;
        const_reg[1]  <= 8'h00;
        const_reg[2]  <= 8'h00;
        const_reg[3]  <= 8'h00;
        misc_reg      <= 6'h00;
        pll_ctrl_reg  <= 7'h00;
        mask_low_reg  <= 8'h00;
        mask_high_reg <= 8'h00;
    end else if (wr_en) begin
        if (idx == `IDX_KEY_VALUE) begin
            key_value_reg <= pwdata_i[7:0];
        end else if (idx == `IDX_KEY_MASK) begin
            key_mask_reg <= pwdata_i[7:0];
        end else if (idx == `IDX_KEY_CTRL) begin
            key_ctrl_reg <= pwdata_i[0];
        end else if (in_const_bank(idx)) begin
            const_reg[idx[1:0]] <= pwdata_i[7:0];
        end else if (idx == `IDX_MISC_CTRL) begin
            misc_reg <= pwdata_i[5:0];
        end else if (idx == `IDX_PLL_CTRL) begin
            pll_ctrl_reg <= pwdata_i[6:0];
        end else if (idx == `IDX_MASK_LOW) begin
            mask_low_reg <= pwdata_i[7:0];
        end else if (idx == `IDX_MASK_HIGH) begin
            mask_high_reg <= pwdata_i[7:0];
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// PLL readback shows power-on values, tracking the fs pins, until the PLL
// control register is first written; a one-clock window would be unreadable
always @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
        boot_reg  <= 1'b1;
        pll_m_reg <= `RESET_M_OTHER;
        pll_n_reg <= `RESET_N;
    end else if (boot_reg) begin
        if (wr_en && idx == `IDX_PLL_CTRL) begin
            boot_reg <= 1'b0;
        end
        pll_n_reg <= `RESET_N;
        if (frequency_select_inputs_i == 2'b00) begin
            pll_m_reg <= `RESET_M_FS0;
        end else if (frequency_select_inputs_i == 2'b01) begin
            pll_m_reg <= `RESET_M_FS1;
        end else begin
            pll_m_reg <= `RESET_M_OTHER;
        end
    end else if (std_pll) begin
        pll_m_reg <= {1'b0, pll_m_sel_i[6:0]};
        pll_n_reg <= {2'b00, pll_n_sel_i[5:0]};
    end else begin
        pll_m_reg <= vco_divider_sel_i;
        pll_n_reg <= {3'b000, ref_divider_sel_i[4:0]};
    end
end

////////////////////////////////////////////////////////////////////////////////
// signature: cleared while control low, accumulates over one visible frame
always @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
        sig_state_reg <= ST_IDLE;
        sig_red_reg   <= `SIG_SEED;
        sig_green_reg <= `SIG_SEED;
        sig_blue_reg  <= `SIG_SEED;
        latched_reg   <= 3'b000;
    end else begin
        if (active_line) begin
            latched_reg <= raw_compare_i;
        end
        case (sig_state_reg)
            ST_IDLE: begin
                sig_red_reg   <= `SIG_SEED;
                sig_green_reg <= `SIG_SEED;
                sig_blue_reg  <= `SIG_SEED;
                if (misc_reg[`MISC_SIG_CTRL] && !blank_b_i) begin
                    sig_state_reg <= ST_RUN;
                end
            end
            ST_RUN: begin
                if (!misc_reg[`MISC_SIG_CTRL]) begin
                    sig_state_reg <= ST_IDLE;
                end else if (sig_window) begin
                    sig_red_reg   <= sig_step(sig_red_reg, dac_red_i);
                    sig_green_reg <= sig_step(sig_green_reg, dac_green_i);
                    sig_blue_reg  <= sig_step(sig_blue_reg, dac_blue_i);
                end else if (sig_red_reg != `SIG_SEED || sig_green_reg != `SIG_SEED) begin
                    sig_state_reg <= ST_DONE;
                end
            end
            ST_DONE: begin
                // hold until software drops the control bit
                if (!misc_reg[`MISC_SIG_CTRL]) begin
                    sig_state_reg <= ST_IDLE;
                end
            end
            default: sig_state_reg <= ST_IDLE;
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////////
always @* begin
    if (idx == `IDX_REVISION) begin
        rd_byte = `REVISION_VALUE;
    end else if (idx == `IDX_PRODUCT_ID) begin
        rd_byte = `PRODUCT_ID_VALUE;
    end else if (idx == `IDX_KEY_VALUE) begin
        rd_byte = key_value_reg;
    end else if (idx == `IDX_KEY_MASK) begin
        rd_byte = key_mask_reg;
    end else if (idx == `IDX_KEY_CTRL) begin
        rd_byte = {7'h00, key_ctrl_reg};
    end else if (idx == `IDX_SENSE) begin
        rd_byte = {lat_sense, latched_reg, raw_sense, raw_compare_i};
    end else if (idx == `IDX_SIG_STATUS) begin
        rd_byte = {7'h00, sig_state_reg[2]};
    end else if (idx == `IDX_SIG_RED) begin
        rd_byte = sig_red_reg;
    end else if (idx == `IDX_SIG_GREEN) begin
        rd_byte = sig_green_reg;
    end else if (idx == `IDX_SIG_BLUE) begin
        rd_byte = sig_blue_reg;
    end else if (idx == `IDX_PLL_P) begin
        rd_byte = std_pll ? {5'h00, pll_p_sel_i[2:0]} : 8'h00;
    end else if (idx == `IDX_PLL_C) begin
        rd_byte = std_pll ? {6'h00, pll_c_sel_i[1:0]} : 8'h00;
    end else if (idx == `IDX_PLL_M) begin
        rd_byte = pll_m_reg;
    end else if (idx == `IDX_PLL_N) begin
        rd_byte = pll_n_reg;
    end else if (idx == `IDX_MASK_LOW) begin
        rd_byte = mask_low_reg;
    end else if (idx == `IDX_MASK_HIGH) begin
        rd_byte = mask_high_reg;
    end else if (in_const_bank(idx)) begin
        rd_byte = const_reg[idx[1:0]];
    end else if (idx == `IDX_MISC_CTRL) begin
        rd_byte = {2'b00, misc_reg};
    end else if (idx == `IDX_PLL_CTRL) begin
        rd_byte = {1'b0, pll_ctrl_reg};
    end else begin
        rd_byte = 8'h00;
    end
end

////////////////////////////////////////////////////////////////////////////////
// zero-wait slave: pready rises in the access cycle's own clock
always @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
        pready_o  <= 1'b0;
        prdata_o  <= 32'h00000000;
        pslverr_o <= 1'b0;
    end else begin
        pready_o  <= psel_i & ~penable_i;
        prdata_o  <= (psel_i & ~penable_i & ~pwrite_i) ? {24'h000000, rd_byte} : 32'h0;
        pslverr_o <= 1'b0;
    end
end

////////////////////////////////////////////////////////////////////////////////
// display-side outputs: one clock behind their sources
integer k;
always @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
        pixel_port_o                <= 64'h0;
        masked_key_o                <= 8'h00;
        key_active_o                <= 1'b0;
        second_buffer_suppress_o    <= 1'b0;
        colour_constants_o          <= 32'h00000000;
        sense_b_o                   <= 1'b0;
        pll_source_select_o         <= 3'h0;
        internal_frequency_select_o <= 4'h0;
    end else begin
        for (k = 0; k < 16; k = k + 1) begin
            if (misc_reg[`MISC_MASK_EN] &&
                ((k < 8) ? mask_low_reg[k % 8] : mask_high_reg[k % 8])) begin
                pixel_port_o[4*k +: 4] <= 4'h0;
            end else begin
                pixel_port_o[4*k +: 4] <= pixel_port_i[4*k +: 4];
            end
        end
        masked_key_o <= key_value_reg & key_mask_reg;
        // unkeyed modes ignore the bit for keying; 16 RGB double-buffer uses it as suppress
        key_active_o <= key_ctrl_reg & mode_keyed;
        second_buffer_suppress_o <= key_ctrl_reg & mode_db;
        colour_constants_o <= {const_reg[3], const_reg[2], const_reg[1], const_reg[0]};
        sense_b_o <= misc_reg[`MISC_SENSE_SEL] ? lat_sense : raw_sense;
        pll_source_select_o         <= pll_ctrl_reg[2:0];
        internal_frequency_select_o <= pll_ctrl_reg[6:3];
    end
end
endmodule
`default_nettype wire

// ---- src/palette_key_diag_map.vh ----
`ifndef PALETTE_KEY_DIAG_MAP_VH
`define PALETTE_KEY_DIAG_MAP_VH
// register indices; byte address is four times the index
`define IDX_REVISION      12'h000
`define IDX_PRODUCT_ID    12'h001
`define IDX_KEY_VALUE     12'h068
`define IDX_KEY_MASK      12'h06c
`define IDX_KEY_CTRL      12'h078
`define IDX_SENSE         12'h082
`define IDX_SIG_STATUS    12'h083
`define IDX_SIG_RED       12'h084
`define IDX_SIG_GREEN     12'h086
`define IDX_SIG_BLUE      12'h088
`define IDX_PLL_P         12'h08c
`define IDX_PLL_C         12'h08d
`define IDX_PLL_M         12'h08e
`define IDX_PLL_N         12'h08f
`define IDX_MASK_LOW      12'h090
`define IDX_MASK_HIGH     12'h091
`define IDX_CONST_ONE     12'h0a0
`define IDX_CONST_FOUR    12'h0a3
`define IDX_MISC_CTRL     12'h0c0
`define IDX_PLL_CTRL      12'h0c1
// misc control field positions
`define MISC_SENSE_SEL    0
`define MISC_SIG_CTRL     1
`define MISC_MASK_EN      2
`define MISC_BORDER_USED  3
`define MISC_INTERLACE    4
`define MISC_VARIANT_DB   5
// pixel mode codes, PLL source codes, fixed id values, PLL reset values, signature constants
`define MODE_PACKED24     3'h0
`define MODE_RGB16        3'h1
`define MODE_YUV16        3'h2
`define MODE_BPP32        3'h3
`define MODE_VGA          3'h4
`define SRC_STD_A         3'h4
`define SRC_STD_B         3'h5
`define REVISION_VALUE    8'h01
`define PRODUCT_ID_VALUE  8'h5a
`define RESET_M_FS0       8'h05
`define RESET_M_FS1       8'h0e
`define RESET_M_OTHER     8'h00
`define RESET_N           8'h05
`define SIG_SEED          8'h00
`define SIG_POLY          8'h1d
`endif

// ---- dv/key_diag_sva.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "palette_key_diag_map.vh"
module key_diag_sva (
    input wire        mclk_i,
    input wire        rst_b_i,
    input wire        psel_i,
    input wire        penable_i,
    input wire        pwrite_i,
    input wire [13:0] paddr_i,
    input wire        pready_o,
    input wire [31:0] prdata_o,
    input wire        pslverr_o,
    input wire [2:0]  pixel_mode_i,
    input wire [63:0] pixel_port_i,
    input wire [63:0] pixel_port_o,
    input wire        key_active_o,
    input wire        second_buffer_suppress_o,
    input wire        sense_b_o,
    input wire [2:0]  pll_source_select_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);
    wire rd_done = pready_o && !pwrite_i;
    ////////////////////////////////////////////////////////////////////////////
    chk_ready_one_shot: assert property (pready_o |-> (psel_i && penable_i) ##1 !pready_o)
        else $error("pready outside access phase or held");
    chk_upper_zero: assert property (rd_done |-> prdata_o[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    chk_revision_fixed: assert property (rd_done && paddr_i == {`IDX_REVISION, 2'b00}
        |-> prdata_o[7:0] == `REVISION_VALUE)
        else $error("revision value wrong");
    chk_id_fixed: assert property (rd_done && paddr_i == {`IDX_PRODUCT_ID, 2'b00}
        |-> prdata_o[7:0] == `PRODUCT_ID_VALUE)
        else $error("product code wrong");
    chk_pll_p_width: assert property (rd_done && paddr_i == {`IDX_PLL_P, 2'b00}
        && pll_source_select_o[2] |-> prdata_o[7:3] == 5'h0)
        else $error("p readback wider than three bits");
    chk_ref_width: assert property (rd_done && paddr_i == {`IDX_PLL_N, 2'b00}
        && !pll_source_select_o[2] |-> prdata_o[7:5] == 3'h0)
        else $error("reference count wider than five bits");
    chk_key_mode_gate: assert property (key_active_o |->
        $past(pixel_mode_i) == `MODE_YUV16 || $past(pixel_mode_i) == `MODE_BPP32)
        else $error("key active in a mode without keys");
    chk_suppress_mode: assert property (second_buffer_suppress_o
        |-> $past(pixel_mode_i) == `MODE_RGB16)
        else $error("suppress outside 16 bit rgb");
    chk_pixel_masked: assert property ((pixel_port_o & ~$past(pixel_port_i)) == 64'h0)
        else $error("pixel output bit set that input lacked");
    chk_no_error: assert property (pslverr_o == 1'b0)
        else $error("slave error raised");
    cov_read: cover property (rd_done);
    cov_key: cover property (key_active_o);
    cov_supp: cover property (second_buffer_suppress_o);
    cov_sense: cover property ($fell(sense_b_o));
endmodule
bind palette_key_diag_regs key_diag_sva chk (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pready_o(pready_o), .prdata_o(prdata_o), .pslverr_o(pslverr_o),
    .pixel_mode_i(pixel_mode_i), .pixel_port_i(pixel_port_i), .pixel_port_o(pixel_port_o),
    .key_active_o(key_active_o), .second_buffer_suppress_o(second_buffer_suppress_o),
    .sense_b_o(sense_b_o), .pll_source_select_o(pll_source_select_o));
`default_nettype wire

// ---- dv/tb_top.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "palette_key_diag_map.vh"
module tb_top;
    logic        mclk_i = 1'b0;
    logic        rst_b_i = 1'b0;
    logic        psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
    logic [13:0] paddr_i = 14'h0;
    logic [31:0] pwdata_i = 32'h0;
    logic [2:0]  pixel_mode_i = 3'h0, raw_compare_i = 3'h0;
    logic        blank_b_i = 1'b0, border_b_i = 1'b1;
    logic [7:0]  dac_r = 8'h0, dac_g = 8'h0, dac_b = 8'h0;
    logic [7:0]  p_sel = 8'h0, c_sel = 8'h0, m_sel = 8'h0, n_sel = 8'h0;
    logic [7:0]  vco_sel = 8'h0, ref_sel = 8'h0;
    logic [63:0] pixel_port_i = 64'h0, pmask;
    wire         pready_o, pslverr_o, key_active_o, supp_o, sense_b_o;
    wire  [31:0] prdata_o, colour_constants_o;
    wire  [63:0] pixel_port_o;
    wire  [7:0]  masked_key_o;
    wire  [2:0]  src_o;
    wire  [3:0]  ifs_o;
    logic [31:0] rnd = 32'h427c5b00, cval;
    logic [7:0]  kv, km, sr, sg, sb;
    logic [1:0]  fsel = 2'b01;
    logic [31:0] exp_q[$];
    int          num_errors = 0;
    int          check_count = 0;
    palette_key_diag_regs DUT (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
        .pready_o(pready_o), .prdata_o(prdata_o), .pslverr_o(pslverr_o),
        .pixel_mode_i(pixel_mode_i), .raw_compare_i(raw_compare_i), .blank_b_i(blank_b_i),
        .border_b_i(border_b_i), .dac_red_i(dac_r), .dac_green_i(dac_g), .dac_blue_i(dac_b),
        .frequency_select_inputs_i(fsel), .pll_p_sel_i(p_sel), .pll_c_sel_i(c_sel),
        .pll_m_sel_i(m_sel), .pll_n_sel_i(n_sel), .vco_divider_sel_i(vco_sel),
        .ref_divider_sel_i(ref_sel), .pixel_port_i(pixel_port_i), .pixel_port_o(pixel_port_o),
        .masked_key_o(masked_key_o), .key_active_o(key_active_o),
        .second_buffer_suppress_o(supp_o), .colour_constants_o(colour_constants_o),
        .sense_b_o(sense_b_o), .pll_source_select_o(src_o),
        .internal_frequency_select_o(ifs_o));
    initial forever #2 mclk_i = ~mclk_i;
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // reference signature step: shift left, fold polynomial on carry, xor word
    function automatic logic [7:0] sig(input logic [7:0] c, input logic [7:0] d);
        return {c[6:0], 1'b0} ^ (c[7] ? `SIG_POLY : 8'h00) ^ d;
    endfunction
    task automatic tally_and_finish();
        if (exp_q.size() != 0) num_errors++;
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic compare_rd(input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] prdata expected %h seen %h", exp, got);
        end
    endtask
    task automatic compare_out(input string what, input logic [63:0] exp, input logic [63:0] got);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // request held until pready is seen; no latency assumed
    task automatic apb(input logic wr, input logic [11:0] idx, input logic [7:0] d);
        int n;
        @(posedge mclk_i);
        psel_i <= 1'b1; penable_i <= 1'b0; pwrite_i <= wr;
        paddr_i <= {idx, 2'b00}; pwdata_i <= {24'h0, d};
        @(posedge mclk_i);
        penable_i <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 50);
        if (n >= 50) begin
            num_errors++;
            tally_and_finish();
        end
        psel_i <= 1'b0; penable_i <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] idx, input logic [7:0] d);
        apb(1'b1, idx, d);
    endtask
    task automatic rd(input logic [11:0] idx, input logic [7:0] e);
        exp_q.push_back({24'h0, e});
        apb(1'b0, idx, 8'h0);
    endtask
    task automatic settle();
        repeat (3) @(posedge mclk_i);
    endtask
    always @(posedge mclk_i) begin
        if (psel_i && penable_i && !pwrite_i && pready_o === 1'b1) begin
            if (exp_q.size() == 0) compare_out("unexpected read", 64'h0, 64'h1);
            else compare_rd(exp_q.pop_front(), prdata_o);
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge mclk_i);
        rst_b_i <= 1'b1;
        repeat (2) @(posedge mclk_i);
        rd(`IDX_KEY_CTRL, 8'h00);
        rd(`IDX_SIG_STATUS, 8'h00);
        rd(`IDX_PLL_M, `RESET_M_FS1);
        rd(`IDX_PLL_N, `RESET_N);
        wr(`IDX_REVISION, 8'hff);
        wr(`IDX_PRODUCT_ID, ~`PRODUCT_ID_VALUE);
        rd(`IDX_REVISION, `REVISION_VALUE);
        rd(`IDX_PRODUCT_ID, `PRODUCT_ID_VALUE);
        rd(12'h0ff, 8'h00);
        $display("test ids done");
        for (int i = 0; i < 4; i++) begin
            rnd = lfsr(rnd);
            cval[i*8 +: 8] = rnd[7:0];
            wr(`IDX_CONST_ONE + i, rnd[7:0]);
        end
        for (int i = 0; i < 4; i++) rd(`IDX_CONST_ONE + i, cval[i*8 +: 8]);
        compare_out("constants", cval, colour_constants_o);
        $display("test constants done");
        rnd = lfsr(rnd);
        kv = rnd[7:0];
        km = rnd[15:8];
        wr(`IDX_KEY_VALUE, kv);
        wr(`IDX_KEY_MASK, km);
        rd(`IDX_KEY_MASK, km);
        settle();
        compare_out("masked_key", kv & km, masked_key_o);
        for (int v = 0; v < 2; v++) begin
            wr(`IDX_MISC_CTRL, v ? 8'h20 : 8'h00);
            wr(`IDX_KEY_CTRL, 8'hff);
            rd(`IDX_KEY_CTRL, 8'h01);
            for (int m = 0; m < 5; m++) begin
                pixel_mode_i <= m[2:0];
                settle();
                compare_out("key_active", m == 2 || m == 3, key_active_o);
                compare_out("suppress", v == 1 && m == 1, supp_o);
            end
        end
        wr(`IDX_KEY_CTRL, 8'h00);
        pixel_mode_i <= `MODE_RGB16;
        settle();
        compare_out("suppress", 1'b0, supp_o);
        pixel_mode_i <= `MODE_BPP32;
        settle();
        compare_out("key_active", 1'b0, key_active_o);
        $display("test key done");
        rnd = lfsr(rnd);
        wr(`IDX_MASK_LOW, rnd[7:0]);
        wr(`IDX_MASK_HIGH, rnd[15:8]);
        rd(`IDX_MASK_LOW, rnd[7:0]);
        rd(`IDX_MASK_HIGH, rnd[15:8]);
        for (int n = 0; n < 16; n++) pmask[4*n +: 4] = {4{rnd[n]}};
        for (int e = 0; e < 2; e++) begin
            wr(`IDX_MISC_CTRL, e ? 8'h04 : 8'h00);
            rnd = lfsr(rnd);
            pixel_port_i <= {rnd, ~rnd};
            settle();
            compare_out("pixel", {rnd, ~rnd} & ~(e ? pmask : 64'h0), pixel_port_o);
        end
        $display("test mask done");
        blank_b_i <= 1'b1;
        raw_compare_i <= 3'b111;
        settle();
        blank_b_i <= 1'b0;
        raw_compare_i <= 3'b101;
        settle();
        rd(`IDX_SENSE, 8'hf5);
        settle();
        compare_out("sense_b raw", 1'b0, sense_b_o);
        wr(`IDX_MISC_CTRL, 8'h09);
        settle();
        compare_out("sense_b latched", 1'b1, sense_b_o);
        blank_b_i <= 1'b1;
        border_b_i <= 1'b0;
        raw_compare_i <= 3'b010;
        settle();
        rd(`IDX_SENSE, 8'hf2);
        border_b_i <= 1'b1;
        settle();
        rd(`IDX_SENSE, 8'h22);
        $display("test sense done");
        for (int f = 0; f < 3; f += 2) begin
            fsel <= f[1:0];
            rst_b_i <= 1'b0;
            repeat (3) @(posedge mclk_i);
            rst_b_i <= 1'b1;
            repeat (2) @(posedge mclk_i);
            rd(`IDX_PLL_M, f ? `RESET_M_OTHER : `RESET_M_FS0);
            rd(`IDX_PLL_N, `RESET_N);
        end
        $display("test pll reset done");
        rnd = lfsr(rnd);
        {p_sel, c_sel, m_sel, n_sel} <= rnd;
        vco_sel <= ~rnd[7:0];
        ref_sel <= ~rnd[15:8];
        wr(`IDX_PLL_CTRL, 8'h4d);
        settle();
        compare_out("pll_ctrl", {4'h9, 3'h5}, {ifs_o, src_o});
        rd(`IDX_PLL_P, rnd[31:24] & 8'h07);
        rd(`IDX_PLL_C, rnd[23:16] & 8'h03);
        rd(`IDX_PLL_M, rnd[15:8] & 8'h7f);
        rd(`IDX_PLL_N, rnd[7:0] & 8'h3f);
        wr(`IDX_PLL_CTRL, 8'h03);
        rd(`IDX_PLL_M, ~rnd[7:0]);
        rd(`IDX_PLL_N, ~rnd[15:8] & 8'h1f);
        $display("test pll done");
        for (int il = 0; il < 2; il++) begin
            wr(`IDX_MISC_CTRL, il ? 8'h12 : 8'h02);
            blank_b_i <= 1'b0;
            settle();
            {sr, sg, sb} = {3{`SIG_SEED}};
            for (int i = 0; i < 8; i++) begin
                rnd = lfsr(rnd);
                @(posedge mclk_i);
                blank_b_i <= 1'b1;
                // interlace: border low keeps the first words out of the signature
                border_b_i <= !(il && i < 3);
                {dac_r, dac_g, dac_b} <= rnd[23:0] | 24'h010101;
                if (!(il && i < 3)) begin
                    sr = sig(sr, rnd[23:16] | 8'h01);
                    sg = sig(sg, rnd[15:8] | 8'h01);
                    sb = sig(sb, rnd[7:0] | 8'h01);
                end
            end
            @(posedge mclk_i);
            blank_b_i <= 1'b0;
            border_b_i <= 1'b1;
            settle();
            rd(`IDX_SIG_STATUS, 8'h01);
            rd(`IDX_SIG_RED, sr);
            rd(`IDX_SIG_GREEN, sg);
            rd(`IDX_SIG_BLUE, sb);
            wr(`IDX_MISC_CTRL, 8'h00);
            rd(`IDX_SIG_STATUS, 8'h00);
        end
        $display("test signature done");
        settle();
        tally_and_finish();
    end
endmodule
`default_nettype wire
